//--- verilog/sdp_regs.svh
// Constants of the peripheral-transfer read engine: address, bus and field
// widths, and the memory-clock count from read command to data.
// Assumes it is included by its bare name wherever a constant is needed.
//
// Contract
// - Flags and strobe timed on memory clock
// - Closed page: access flag low during activate
// - Plain-open page: close, reactivate, access flag low
// - Transfer-open page: go straight to data phase
// - Direction flag stays high whole transaction
// - Normal read commands, memory space selected
// - Returned data ignored during transfer read
// - Strobe low latency cycles before read data
// - Strobe lead time is 0 to 3 cycles
// - Ordinary access: strobe idle, access flag high
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH

`define SDP_ROW_W   13      // Row address width
`define SDP_COL_W   10      // Column address width
`define SDP_BANK_W  2       // Bank address width
`define SDP_DATA_W  32      // External data bus width
`define SDP_LAT_W   2       // Strobe latency field width
`define SDP_CAS_LAT 3       // Memory clocks from read command to data
`define SDP_CNT_W   3       // Width of the data-phase counter

`endif

//--- verilog/sdp_pkg.sv
// Types shared by the peripheral-transfer read engine.
// Assumes sdp_regs.svh is on the include path.
`include "sdp_regs.svh"

package sdp_pkg;

  // One read request as the arbiter hands it over
  typedef struct packed {
    logic                   xfer;  // Peripheral transfer, not ordinary
    logic [`SDP_BANK_W-1:0] bank;  // Bank
    logic [`SDP_ROW_W-1:0]  row;   // Row
    logic [`SDP_COL_W-1:0]  col;   // Column
  } sdp_req_s;

  // SDRAM command pins, all active low
  typedef struct packed {
    logic cs_n;                    // Memory space select
    logic ras_n;                   // Row strobe
    logic cas_n;                   // Column strobe
    logic we_n;                    // Write enable
  } sdp_cmd_s;

  typedef enum logic [1:0] {
    SDP_ST_IDLE,                   // Waiting for a request
    SDP_ST_ACT,                    // Activate after a precharge
    SDP_ST_RD,                     // Read command due
    SDP_ST_WAIT                    // Counting toward the data phase
  } sdp_state_e;

endpackage : sdp_pkg

//--- verilog/sdp_edge_sync.sv
// Three-flop synchroniser with edge finder for the memory clock pin.
// Assumes the pin is slower than a quarter of the local clock.
`timescale 1ns/1ps
`default_nettype none

module sdp_edge_sync (
  input  wire logic clock,   // Local clock
  input  wire logic rst,     // Asynchronous reset, active high
  input  wire logic pin,     // Asynchronous input
  output logic      rise     // One-cycle pulse on a settled rising edge
);

  logic s1_r, s2_r, s3_r;    // Synchroniser chain
  logic lvl_r, lvl_nxt;      // Settled level
  logic rise_r, rise_nxt;    // Edge pulse

  // A change counts only once the second and third flops agree
  always_comb begin
    lvl_nxt  = (s2_r == s3_r) ? s3_r : lvl_r;
    rise_nxt = lvl_nxt & ~lvl_r;
  end

  // Registers only; the first flop feeds the second alone
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      lvl_r  <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      s1_r   <= pin;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise = rise_r;

endmodule : sdp_edge_sync
`default_nettype wire

//--- verilog/sdp_xfer_read.sv
// Read engine of an SDRAM controller with peripheral-transfer support.
// Assumes requests come from an arbiter on the local clock, and the
// memory clock pin is an asynchronous input far slower than clock.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_regs.svh"

module sdp_xfer_read #(
  parameter int unsigned CAS_LAT = `SDP_CAS_LAT  // Must be 3 to 7
) (
  input  wire logic              clock,                  // Local clock
  input  wire logic              rst,                    // Async reset
  input  wire logic              memory_clock_out,       // Memory clock
  input  wire logic              req_valid,              // Request offered
  input  var  sdp_pkg::sdp_req_s req,                    // Request fields
  output logic                   req_ready,              // Can take one
  input  wire logic [`SDP_LAT_W-1:0] read_strobe_latency, // Lead cycles
  input  wire logic [`SDP_DATA_W-1:0] external_data_bus, // Read data
  output var  sdp_pkg::sdp_cmd_s cmd,                    // SDRAM command
  output logic [`SDP_ROW_W-1:0]  external_address_bus,   // Row or column
  output logic [`SDP_BANK_W-1:0] bank_addr,              // Bank
  output logic                   transfer_access_flag_n, // Low in transfer
  output logic                   transfer_direction_flag, // High = read
  output logic                   transfer_strobe_n,      // Data strobe
  output logic                   rsp_valid,              // Read finished
  output logic [`SDP_DATA_W-1:0] rsp_data                // Ordinary data
);

  localparam int unsigned NB = 1 << `SDP_BANK_W;          // Bank count
  localparam logic [`SDP_CNT_W-1:0] CL = `SDP_CNT_W'(CAS_LAT);
  localparam sdp_pkg::sdp_cmd_s C_DESEL = 4'hf;           // Deselect
  localparam sdp_pkg::sdp_cmd_s C_NOP   = 4'h7;           // No operation
  localparam sdp_pkg::sdp_cmd_s C_ACT   = 4'h3;           // Activate
  localparam sdp_pkg::sdp_cmd_s C_RD    = 4'h5;           // Read
  localparam sdp_pkg::sdp_cmd_s C_PRE   = 4'h2;           // Precharge

  logic mem_rise;                                        // Memory edge

  // True in the memory cycle where the strobe must be low
  function automatic logic strobe_due(
    input logic [`SDP_CNT_W-1:0] c,
    input logic [`SDP_LAT_W-1:0] l
  );
    strobe_due = (c == CL - `SDP_CNT_W'(l));
  endfunction : strobe_due

  sdp_edge_sync u_clk_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (memory_clock_out),
    .rise  (mem_rise)
  );

  // The data bus is a pin group and goes through the same three stages
  logic [`SDP_DATA_W-1:0] ed1_r, ed2_r, ed3_r;            // Data pipeline

  sdp_pkg::sdp_state_e state_r, state_nxt;               // Sequencer
  sdp_pkg::sdp_req_s   req_r, req_nxt;                   // Held request
  logic                pend_r, pend_nxt;                 // Request held
  logic                ready_r, ready_nxt;               // Ready output
  logic [`SDP_LAT_W-1:0] lat_r, lat_nxt;                 // Latched lead
  logic [`SDP_CNT_W-1:0] cnt_r, cnt_nxt;                 // Data-phase count
  sdp_pkg::sdp_cmd_s   cmd_r, cmd_nxt;                   // Command pins
  logic [`SDP_ROW_W-1:0] addr_r, addr_nxt;               // Address pins
  logic [`SDP_BANK_W-1:0] ba_r, ba_nxt;                  // Bank pins
  logic                acc_n_r, acc_n_nxt;               // Access flag
  logic                dir_r, dir_nxt;                   // Direction flag
  logic                stb_n_r, stb_n_nxt;               // Strobe
  logic                rv_r, rv_nxt;                     // Response pulse
  logic [`SDP_DATA_W-1:0] rd_r, rd_nxt;                  // Response data
  logic                open_r [NB];                      // Page open
  logic                open_nxt [NB];
  logic [`SDP_ROW_W-1:0] row_r [NB];                     // Open row
  logic [`SDP_ROW_W-1:0] row_nxt [NB];
  logic                xtb_r [NB];                       // Opened by transfer
  logic                xtb_nxt [NB];
  logic                hit;                              // Row already open

  assign hit = open_r[req_r.bank] && (row_r[req_r.bank] == req_r.row);

  // Next state; everything facing the memory moves on a memory edge only
  always_comb begin
    state_nxt = state_r;
    req_nxt   = req_r;
    pend_nxt  = pend_r;
    ready_nxt = ready_r;
    lat_nxt   = lat_r;
    cnt_nxt   = cnt_r;
    cmd_nxt   = cmd_r;
    addr_nxt  = addr_r;
    ba_nxt    = ba_r;
    acc_n_nxt = acc_n_r;
    dir_nxt   = 1'b1;
    stb_n_nxt = stb_n_r;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    open_nxt  = open_r;
    row_nxt   = row_r;
    xtb_nxt   = xtb_r;
    // Take a request; the latency is frozen so a mid-read change is safe
    if (req_valid && ready_r) begin
      req_nxt   = req;
      lat_nxt   = read_strobe_latency;
      pend_nxt  = 1'b1;
      ready_nxt = 1'b0;
    end
    if (mem_rise) begin
      cmd_nxt   = pend_r ? C_NOP : C_DESEL;
      stb_n_nxt = 1'b1;
      unique case (state_r)
        sdp_pkg::SDP_ST_IDLE: begin
          if (pend_r) begin
            ba_nxt = req_r.bank;
            if (hit && (!req_r.xfer || xtb_r[req_r.bank])) begin
              // Same row: straight to the read command
              cmd_nxt   = C_RD;
              addr_nxt  = `SDP_ROW_W'(req_r.col);
              acc_n_nxt = ~req_r.xfer;
              xtb_nxt[req_r.bank] = req_r.xfer;
              cnt_nxt   = '0;
              stb_n_nxt = ~(req_r.xfer && strobe_due('0, lat_r));
              state_nxt = sdp_pkg::SDP_ST_WAIT;
            end else if (open_r[req_r.bank]) begin
              // Wrong row or plain-opened page: close it first
              cmd_nxt   = C_PRE;
              addr_nxt  = '0;
              open_nxt[req_r.bank] = 1'b0;
              state_nxt = sdp_pkg::SDP_ST_ACT;
            end else begin
              cmd_nxt   = C_ACT;
              addr_nxt  = req_r.row;
              acc_n_nxt = ~req_r.xfer;
              open_nxt[req_r.bank] = 1'b1;
              row_nxt[req_r.bank]  = req_r.row;
              xtb_nxt[req_r.bank]  = req_r.xfer;
              state_nxt = sdp_pkg::SDP_ST_RD;
            end
          end
        end
        sdp_pkg::SDP_ST_ACT: begin
          // Reopen after the precharge with the flag warning glue logic
          cmd_nxt   = C_ACT;
          addr_nxt  = req_r.row;
          acc_n_nxt = ~req_r.xfer;
          open_nxt[req_r.bank] = 1'b1;
          row_nxt[req_r.bank]  = req_r.row;
          xtb_nxt[req_r.bank]  = req_r.xfer;
          state_nxt = sdp_pkg::SDP_ST_RD;
        end
        sdp_pkg::SDP_ST_RD: begin
          cmd_nxt   = C_RD;
          addr_nxt  = `SDP_ROW_W'(req_r.col);
          cnt_nxt   = '0;
          stb_n_nxt = ~(req_r.xfer && strobe_due('0, lat_r));
          state_nxt = sdp_pkg::SDP_ST_WAIT;
        end
        sdp_pkg::SDP_ST_WAIT: begin
          cnt_nxt   = cnt_r + `SDP_CNT_W'(1);
          // Lead time of 0..3 cycles ahead of the data phase
          stb_n_nxt = ~(req_r.xfer && strobe_due(cnt_nxt, lat_r));
          if (cnt_nxt == CL) begin
            // Transfer data belongs to the peripheral and is not kept
            if (!req_r.xfer) begin
              rd_nxt = ed3_r;
            end
            rv_nxt    = 1'b1;
            pend_nxt  = 1'b0;
            ready_nxt = 1'b1;
            acc_n_nxt = 1'b1;
            cmd_nxt   = C_DESEL;
            state_nxt = sdp_pkg::SDP_ST_IDLE;
          end
        end
      endcase
    end
    // Ready only once the strobe of a finished read has gone idle, so a new
    // request never sees a stale strobe from the previous transfer
    ready_nxt = ~pend_nxt && stb_n_nxt;
  end

  // Registers only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ed1_r   <= '0;
      ed2_r   <= '0;
      ed3_r   <= '0;
      state_r <= sdp_pkg::SDP_ST_IDLE;
      req_r   <= '0;
      pend_r  <= 1'b0;
      ready_r <= 1'b0;
      lat_r   <= '0;
      cnt_r   <= '0;
      cmd_r   <= C_DESEL;
      addr_r  <= '0;
      ba_r    <= '0;
      acc_n_r <= 1'b1;
      dir_r   <= 1'b1;
      stb_n_r <= 1'b1;
      rv_r    <= 1'b0;
      rd_r    <= '0;
      for (int i = 0; i < NB; i++) begin
        open_r[i] <= 1'b0;
        row_r[i]  <= '0;
        xtb_r[i]  <= 1'b0;
      end
    end else begin
      ed1_r   <= external_data_bus;
      ed2_r   <= ed1_r;
      ed3_r   <= ed2_r;
      state_r <= state_nxt;
      req_r   <= req_nxt;
      pend_r  <= pend_nxt;
      ready_r <= ready_nxt;
      lat_r   <= lat_nxt;
      cnt_r   <= cnt_nxt;
      cmd_r   <= cmd_nxt;
      addr_r  <= addr_nxt;
      ba_r    <= ba_nxt;
      acc_n_r <= acc_n_nxt;
      dir_r   <= dir_nxt;
      stb_n_r <= stb_n_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      open_r  <= open_nxt;
      row_r   <= row_nxt;
      xtb_r   <= xtb_nxt;
    end
  end

  assign req_ready               = ready_r;
  assign cmd                     = cmd_r;
  assign external_address_bus    = addr_r;
  assign bank_addr               = ba_r;
  assign transfer_access_flag_n  = acc_n_r;
  assign transfer_direction_flag = dir_r;
  assign transfer_strobe_n       = stb_n_r;
  assign rsp_valid               = rv_r;
  assign rsp_data                = rd_r;

  // Checks
  property p_act_flag;
    @(posedge clock) disable iff (rst)
    (cmd_r == C_ACT && req_r.xfer) |-> !acc_n_r;
  endproperty
  a_act_flag: assert property (p_act_flag)
    else $error("access flag high during transfer activate");

  property p_reopen;
    @(posedge clock) disable iff (rst)
    (mem_rise && state_r == sdp_pkg::SDP_ST_IDLE && pend_r && req_r.xfer
     && hit && !xtb_r[req_r.bank]) |=> (cmd_r == C_PRE);
  endproperty
  a_reopen: assert property (p_reopen)
    else $error("plain-opened page not closed for transfer");

  property p_direct;
    @(posedge clock) disable iff (rst)
    (mem_rise && state_r == sdp_pkg::SDP_ST_IDLE && pend_r && req_r.xfer
     && hit && xtb_r[req_r.bank]) |=> (cmd_r == C_RD);
  endproperty
  a_direct: assert property (p_direct)
    else $error("transfer-opened page not read directly");

  property p_dir_high;
    @(posedge clock) disable iff (rst)
    (pend_r && req_r.xfer) |-> dir_r;
  endproperty
  a_dir_high: assert property (p_dir_high)
    else $error("direction flag low during transfer read");

  property p_select;
    @(posedge clock) disable iff (rst)
    (state_r != sdp_pkg::SDP_ST_IDLE) |-> !cmd_r.cs_n;
  endproperty
  a_select: assert property (p_select)
    else $error("memory space not selected mid transaction");

  property p_discard;
    @(posedge clock) disable iff (rst)
    (rv_r && req_r.xfer) |-> $stable(rd_r);
  endproperty
  a_discard: assert property (p_discard)
    else $error("transfer data captured");

  property p_strobe_time;
    @(posedge clock) disable iff (rst)
    !stb_n_r |-> (req_r.xfer && cnt_r == CL - `SDP_CNT_W'(lat_r));
  endproperty
  a_strobe_time: assert property (p_strobe_time)
    else $error("strobe low at wrong cycle");

  property p_plain;
    @(posedge clock) disable iff (rst)
    (pend_r && !req_r.xfer) |-> (acc_n_r && stb_n_r);
  endproperty
  a_plain: assert property (p_plain)
    else $error("transfer signals active in ordinary read");

  property p_mem_timed;
    @(posedge clock) disable iff (rst)
    !$past(mem_rise) |-> ($stable(cmd_r) && $stable(stb_n_r)
                          && $stable(acc_n_r));
  endproperty
  a_mem_timed: assert property (p_mem_timed)
    else $error("memory pins moved off a memory clock edge");

  c_xfer_done: cover property (@(posedge clock) disable iff (rst)
    rv_r && req_r.xfer);
  c_plain_done: cover property (@(posedge clock) disable iff (rst)
    rv_r && !req_r.xfer);
  c_reopen: cover property (@(posedge clock) disable iff (rst)
    cmd_r == C_PRE ##[1:40] cmd_r == C_ACT && req_r.xfer);

endmodule : sdp_xfer_read
`default_nettype wire

//--- test/sdp_sdram_model.sv
// Behavioural SDRAM on the far side: tracks open rows, answers reads.
// Assumes commands are settled at every rising memory clock edge.
// Only ever used as an SDRAM memory space.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_regs.svh"

module sdp_sdram_model #(
  parameter int unsigned CAS_LAT = 3  // Memory clocks to read data
) (
  input  wire logic                   memory_clock_out,     // Memory clock
  input  var  sdp_pkg::sdp_cmd_s      cmd,                  // Command pins
  input  wire logic [`SDP_ROW_W-1:0]  external_address_bus, // Row or col
  input  wire logic [`SDP_BANK_W-1:0] bank_addr,            // Bank
  output logic [`SDP_DATA_W-1:0]      external_data_bus     // Read data
);
  logic [`SDP_ROW_W-1:0]  row_r [4]; // Open row per bank
  logic [`SDP_DATA_W-1:0] last_r;    // Last value put on the bus
  logic [`SDP_DATA_W-1:0] dat_q[$];  // Words waiting for their edge
  int unsigned            due_q[$];  // Edge numbers when words go out
  int unsigned            ecnt;      // Rising edges seen
  int unsigned            end_at;    // Edge at which the bus is let go

  initial begin
    last_r = 32'h0;
    ecnt = 0;
    end_at = 0;
    external_data_bus = 32'h0;
  end

  // Sample the command, then drive data a little after the edge
  always @(posedge memory_clock_out) begin
    ecnt++;
    if (cmd == 4'h3) begin
      row_r[bank_addr] = external_address_bus;
    end
    if (cmd == 4'h5) begin
      due_q.push_back(ecnt + CAS_LAT - 1);
      dat_q.push_back({7'h2b, bank_addr, row_r[bank_addr],
                       external_address_bus[9:0]});
    end
    #1;
    if (due_q.size() > 0 && due_q[0] == ecnt) begin
      void'(due_q.pop_front());
      last_r = dat_q.pop_front();
      end_at = ecnt + 2;
    end else if (ecnt >= end_at) begin
      // Released bus: keep toggling so stale data never looks valid
      last_r = ~last_r;
    end
    external_data_bus = last_r;
  end
endmodule : sdp_sdram_model
`default_nettype wire

//--- test/sdp_xfer_read_tb.sv
// Self-checking bench of the peripheral-transfer read engine.
// Assumes the SDRAM model and the design sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_regs.svh"

module sdp_xfer_read_tb;
  localparam int unsigned CL = 3;          // CAS latency in use
  logic                    clock;          // Local clock
  logic                    rst;            // Reset
  logic                    memory_clock_out; // Memory clock pin
  logic                    req_valid;      // Request offered
  sdp_pkg::sdp_req_s       req;            // Request fields
  logic                    req_ready;      // Engine can take one
  logic [1:0]              read_strobe_latency; // Strobe lead
  logic [31:0]             ext_data;       // Data bus from memory
  sdp_pkg::sdp_cmd_s       cmd;            // Command pins
  logic [12:0]             ext_addr;       // Address pins
  logic [1:0]              bank_addr;      // Bank pins
  logic                    acc_n;          // Access flag
  logic                    dir;            // Direction flag
  logic                    strobe_n;       // Transfer strobe
  logic                    rsp_valid;      // Read finished
  logic [31:0]             rsp_data;       // Ordinary data
  int                      n_fail;         // Mismatches
  int                      num_checks;     // Comparisons
  logic [31:0]             rnd;            // Random state
  logic [31:0]             last_ord;       // Last ordinary data
  logic                    pg_open [4];    // Bench page model
  logic                    pg_x [4];       // Page opened by transfer
  logic [12:0]             pg_row [4];     // Open row

  sdp_xfer_read #(.CAS_LAT(CL)) u_dut (
    .clock(clock), .rst(rst), .memory_clock_out(memory_clock_out),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .read_strobe_latency(read_strobe_latency),
    .external_data_bus(ext_data), .cmd(cmd),
    .external_address_bus(ext_addr), .bank_addr(bank_addr),
    .transfer_access_flag_n(acc_n), .transfer_direction_flag(dir),
    .transfer_strobe_n(strobe_n), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));

  sdp_sdram_model #(.CAS_LAT(CL)) u_mem (
    .memory_clock_out(memory_clock_out), .cmd(cmd),
    .external_address_bus(ext_addr), .bank_addr(bank_addr),
    .external_data_bus(ext_data));

  // Local clock, 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Free-running memory clock, 160 ns, phase unrelated to the local one
  initial begin
    memory_clock_out = 1'b0;
    #37;
    forever #80 memory_clock_out = ~memory_clock_out;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // One read: offer, watch the memory pins edge by edge, then compare
  task automatic do_read(input logic x, input logic [1:0] b,
                         input logic [12:0] r, input logic [9:0] c,
                         input logic [1:0] l);
    int          k;
    int          edges;
    int          rd_at;
    int          st_at;
    int          n_act;
    int          n_pre;
    int          n_rd;
    int          bad;
    int          e_act;
    int          e_pre;
    int          got;
    logic        pin_q;
    logic [31:0] pat;
    pat = {7'h2b, b, r, c};
    // Hit when the row is open and, for a transfer, opened by one
    e_act = 1;
    e_pre = pg_open[b] ? 1 : 0;
    if (pg_open[b] && pg_row[b] == r && (!x || pg_x[b])) begin
      e_act = 0;
      e_pre = 0;
    end
    for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clock);
    if (k == 200) begin
      check("ready wait", 32'h1, 32'h0);
      give_verdict();
    end
    req_valid = 1'b1;
    req = '{xfer: x, bank: b, row: r, col: c};
    read_strobe_latency = l;
    @(negedge clock);
    req_valid = 1'b0;
    // Scramble fields after the take; the engine must have latched them
    req.col = ~c;
    read_strobe_latency = ~l;
    {edges, n_act, n_pre, n_rd, bad, got} = '0;
    rd_at = 999;
    st_at = 999;
    pin_q = memory_clock_out;
    for (k = 0; k < 900; k++) begin
      if (memory_clock_out && !pin_q) begin
        edges++;
        if (cmd === 4'h3) begin
          n_act++;
          bad += (acc_n !== !x || ext_addr !== r) ? 1 : 0;
        end
        n_pre += (cmd === 4'h2) ? 1 : 0;
        if (cmd === 4'h5) begin
          n_rd++;
          rd_at = edges;
          bad += (bank_addr !== b || ext_addr !== {3'h0, c}) ? 1 : 0;
        end
      end
      if (strobe_n === 1'b0 && st_at == 999) st_at = edges;
      bad += (dir !== 1'b1) ? 1 : 0;
      bad += (!x && (strobe_n !== 1'b1 || acc_n !== 1'b1)) ? 1 : 0;
      pin_q = memory_clock_out;
      // After the response, watch three more cycles and leave
      if (rsp_valid === 1'b1 && got == 0) begin
        got = 1;
        k = 896;
      end
      @(negedge clock);
    end
    if (got == 0 || (st_at == 999 && x)) begin
      check("rsp wait", 32'h1, 32'h0);
      give_verdict();
    end
    check("activates", n_act, e_act);
    check("precharges", n_pre, e_pre);
    check("read commands", n_rd, 1);
    check("pin levels", bad, 0);
    if (x) check("strobe lead", st_at - rd_at, CL - 1 - l);
    check("read data", rsp_data, x ? last_ord : pat);
    if (!x) last_ord = pat;
    pg_open[b] = 1'b1;
    pg_row[b] = r;
    pg_x[b] = x;
  endtask : do_read

  // Hand-written corners: closed, hit, ordinary hit, reopen, other row
  localparam logic [3:0] XS  = 4'b1011;
  localparam logic [7:0] XS2 = 8'b1101_1011;
  localparam logic [7:0] BS  = 8'b1110_0000;
  logic [12:0] rows [8];
  logic [1:0]  lats [8];

  // Main sequence, inputs changed on falling edges
  initial begin
    n_fail = 0;
    num_checks = 0;
    rnd = 32'd85125;
    last_ord = 32'h0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    read_strobe_latency = 2'h0;
    rows = '{13'h5, 13'h5, 13'h5, 13'h5, 13'h7, 13'h9, 13'h9, 13'h9};
    lats = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h2, 2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 4; i++) pg_open[i] = 1'b0;
    repeat (4) @(negedge clock);
    check("reset pins", {cmd, acc_n, dir, strobe_n, rsp_valid, req_ready},
          {4'hf, 3'b111, 2'b00});
    check("reset data", rsp_data, 32'h0);
    rst = 1'b0;
    @(negedge clock);
    check("ready after reset", req_ready, 1'b1);
    for (int i = 0; i < 8; i++) begin
      do_read(XS2[7 - i], {1'b0, BS[7 - i]}, rows[i], 10'h3a0 + i,
              lats[i]);
    end
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      do_read(rnd[0], rnd[2:1], {12'h0, rnd[3]}, rnd[13:4], rnd[15:14]);
    end
    give_verdict();
  end
endmodule : sdp_xfer_read_tb
`default_nettype wire
